//--- logic/cusc_top.sv
// Purpose: processor and bus engine clock select plus detector duty control
// Assumes: APB slave on ref_clk, sleep and duty trim arrive from other domains
// Notes: unmapped addresses answer with pslverr and read zero
`timescale 1ns/1ps
`default_nettype none
module cusc_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_pin,
    input wire logic [1:0] duty_trim_pin,
    output logic processor_clock_sel,
    output logic bus_engine_clock_sel,
    output logic bus_engine_halve,
    output logic [1:0] sleep_timer_sel,
    output logic [2:0] processor_speed,
    output logic low_voltage_detect_en
);
    import cusc_pkg::*;

    // ==========================================================
    // address decode
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
        hit = addr == ofs;
    endfunction

    logic [7:0] clk_cfg_reg;
    logic [7:0] osc_ctl0_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic cpu_sel_reg;
    logic usb_sel_reg;
    logic halve_reg;
    logic [1:0] sleep_sel_reg;
    logic [2:0] speed_reg;
    logic det_en_reg;
    logic sleep_d_reg;
    wire [2:0] sync_q;

    wire access = psel & penable;
    wire first_access = access & ~pready_reg;
    wire commit = access & pready_reg;
    wire sel_cfg = hit(paddr, CUSC_CLK_CFG_OFS);
    wire sel_osc = hit(paddr, CUSC_OSC_CTL0_OFS);
    wire mapped = sel_cfg | sel_osc;
    wire wr_cfg = commit & pwrite & sel_cfg;
    wire wr_osc = commit & pwrite & sel_osc;

    // ==========================================================
    // register next values
    // reserved bits are not stored and read as zero
    wire [7:0] cfg_mask = 8'h61;
    wire [7:0] osc_mask = 8'h3f;
    wire [7:0] clk_cfg_next = wr_cfg ? (pwdata[7:0] & cfg_mask) : clk_cfg_reg;
    wire [7:0] osc_ctl0_next = wr_osc ? (pwdata[7:0] & osc_mask) : osc_ctl0_reg;
    wire [31:0] rd_word = sel_cfg ? {24'h00_0000, clk_cfg_reg} :
                          sel_osc ? {24'h00_0000, osc_ctl0_reg} : CUSC_RDATA_RST;
    wire [31:0] prdata_next = (first_access & ~pwrite) ? rd_word : prdata_reg;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            clk_cfg_reg <= CUSC_CLK_CFG_RST;
            osc_ctl0_reg <= CUSC_OSC_CTL0_RST;
        end else begin
            clk_cfg_reg <= clk_cfg_next;
            osc_ctl0_reg <= osc_ctl0_next;
        end
    end

    // ==========================================================
    // apb answer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= CUSC_RDATA_RST;
        end else begin
            pready_reg <= first_access;
            pslverr_reg <= first_access & ~mapped;
            prdata_reg <= prdata_next;
        end
    end

    // ==========================================================
    // synchronisers for sleep and duty trim
    wire [2:0] async_in = {duty_trim_pin, sleep_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            logic sync1_reg;
            logic sync2_reg;
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                end else begin
                    sync1_reg <= async_in[gi];
                    sync2_reg <= sync1_reg;
                end
            end
            assign sync_q[gi] = sync2_reg;
        end
    endgenerate

    wire sleeping = sync_q[0];
    wire [1:0] duty_trim = sync_q[2:1];

    // ==========================================================
    // detector duty cycling
    wire no_buzz = osc_ctl0_reg[CUSC_NO_BUZZ_BIT];
    wire duty_on;

    // sleep interval field is deliberately not connected here
    cusc_duty_timer u_duty (
        .clk(ref_clk),
        .resetn(resetn),
        .run(sleeping),
        .duty_trim(duty_trim),
        .duty_on(duty_on)
    );

    // awake: detector on; asleep: forced on or duty cycled
    // delayed sleep lines up with the timer output, so the first on window joins the awake level
    wire det_en_next = ~sleep_d_reg | no_buzz | duty_on;

    // ==========================================================
    // clock select outputs
    wire usb_sel = clk_cfg_reg[CUSC_USB_SEL_BIT];
    wire usb_div_dis = clk_cfg_reg[CUSC_USB_DIV_DIS_BIT];
    // divider disable only counts with the external source
    wire halve_next = ~usb_sel | ~usb_div_dis;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cpu_sel_reg <= 1'b0;
            usb_sel_reg <= 1'b0;
            halve_reg <= 1'b1;
            sleep_sel_reg <= 2'h0;
            speed_reg <= 3'h0;
            det_en_reg <= 1'b1;
            sleep_d_reg <= 1'b0;
        end else begin
            cpu_sel_reg <= clk_cfg_reg[CUSC_CPU_SEL_BIT];
            usb_sel_reg <= usb_sel;
            halve_reg <= halve_next;
            sleep_sel_reg <= osc_ctl0_reg[CUSC_SLEEP_LSB +: CUSC_SLEEP_W];
            speed_reg <= osc_ctl0_reg[CUSC_SPEED_LSB +: CUSC_SPEED_W];
            det_en_reg <= det_en_next;
            sleep_d_reg <= sleeping;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign processor_clock_sel = cpu_sel_reg;
    assign bus_engine_clock_sel = usb_sel_reg;
    assign bus_engine_halve = halve_reg;
    assign sleep_timer_sel = sleep_sel_reg;
    assign processor_speed = speed_reg;
    assign low_voltage_detect_en = det_en_reg;

    // ==========================================================
    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_cfg_write;
        psel && penable && pready_reg && pwrite && (paddr == CUSC_CLK_CFG_OFS);
    endsequence

    sequence s_osc_write;
        psel && penable && pready_reg && pwrite && (paddr == CUSC_OSC_CTL0_OFS);
    endsequence

    cfg_write_out_a: assert property (
        s_cfg_write |-> ##2 (processor_clock_sel == $past(pwdata[0], 2))
            && (bus_engine_clock_sel == $past(pwdata[5], 2)))
        else $error("clock select outputs do not follow config write");

    osc_write_out_a: assert property (
        s_osc_write |-> ##2 (processor_speed == $past(pwdata[2:0], 2))
            && (sleep_timer_sel == $past(pwdata[4:3], 2)))
        else $error("speed or sleep field does not follow oscillator write");

    osc_readback_a: assert property (
        psel && penable && !pready_reg && !pwrite && (paddr == CUSC_OSC_CTL0_OFS)
            |=> pready && (prdata[31:6] == 26'h000_0000) && (prdata[5:0] == osc_ctl0_reg[5:0]))
        else $error("oscillator register readback wrong");

    duty_gate_a: assert property (
        sleep_d_reg && !no_buzz && !duty_on |=> !low_voltage_detect_en)
        else $error("detector enabled outside duty window");

    no_buzz_hold_a: assert property (
        no_buzz && $past(no_buzz) |-> low_voltage_detect_en)
        else $error("detector dropped while forced on");

    sleep_field_free_a: assert property (
        sleep_d_reg && !no_buzz && $stable(duty_on) && $changed(osc_ctl0_reg[4:3])
            |=> low_voltage_detect_en == $past(duty_on))
        else $error("sleep interval change disturbed detector duty");

    halve_internal_a: assert property (
        !usb_sel ##1 !$past(usb_sel) |-> bus_engine_halve)
        else $error("internal bus clock not halved");

    halve_external_a: assert property (
        usb_sel && usb_div_dis |=> !bus_engine_halve)
        else $error("external bus clock halved despite divider disable");

    halve_divided_a: assert property (
        usb_sel && !usb_div_dis |=> bus_engine_halve)
        else $error("external bus clock not halved with divider enabled");

    sequence s_read_first;
        psel && penable && !pready_reg && !pwrite;
    endsequence

    sequence s_unmapped_commit;
        psel && penable && pready_reg && !mapped;
    endsequence

    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("pready stood for more than one cycle");

    slverr_ready_a: assert property (
        pslverr |-> pready)
        else $error("pslverr raised without pready");

    unmapped_err_a: assert property (
        psel && penable && !pready_reg && !mapped |=> pready && pslverr)
        else $error("unmapped access not answered with an error");

    unmapped_write_a: assert property (
        s_unmapped_commit |=> $stable(clk_cfg_reg) && $stable(osc_ctl0_reg))
        else $error("unmapped write changed a register");

    cfg_write_lands_a: assert property (
        s_cfg_write |=> clk_cfg_reg == ($past(pwdata[7:0]) & cfg_mask))
        else $error("config write did not land");

    osc_write_lands_a: assert property (
        s_osc_write |=> osc_ctl0_reg == ($past(pwdata[7:0]) & osc_mask))
        else $error("oscillator write did not land");

    cfg_readback_a: assert property (
        s_read_first ##0 sel_cfg |=> pready && (prdata == {24'h00_0000, clk_cfg_reg}))
        else $error("config register readback wrong");

    read_hold_a: assert property (
        !(psel && penable && !pready_reg && !pwrite) |=> $stable(prdata))
        else $error("read data changed without a read");

    cfg_out_hold_a: assert property (
        !wr_cfg |-> ##2 ($stable(processor_clock_sel) && $stable(bus_engine_clock_sel)))
        else $error("clock select changed without a config write");

    osc_out_hold_a: assert property (
        !wr_osc |-> ##2 ($stable(processor_speed) && $stable(sleep_timer_sel)))
        else $error("speed or sleep field changed without a write");

    awake_on_a: assert property (
        !sleep_d_reg |=> low_voltage_detect_en)
        else $error("detector off while awake");

    duty_pass_a: assert property (
        sleep_d_reg && !no_buzz && duty_on |=> low_voltage_detect_en)
        else $error("detector off inside duty window");

endmodule
`default_nettype wire

//--- common/cusc_pkg.sv
// Purpose: constants shared by the clock select and detector duty logic
// Assumes: 20 MHz ref_clk, APB byte addressing, 12-bit address space
// Notes: all register values are eight bits wide in the low byte of the bus word
package cusc_pkg;

    // ==========================================================
    // register map
    localparam logic [11:0] CUSC_CLK_CFG_OFS = 12'h030;
    localparam logic [11:0] CUSC_OSC_CTL0_OFS = 12'h1e0;
    localparam logic [7:0] CUSC_CLK_CFG_RST = 8'h00;
    localparam logic [7:0] CUSC_OSC_CTL0_RST = 8'h00;
    localparam logic [31:0] CUSC_RDATA_RST = 32'h0000_0000;

    // ==========================================================
    // cpu_usb_clock_config fields
    localparam int CUSC_CPU_SEL_BIT = 0;
    localparam int CUSC_USB_SEL_BIT = 5;
    localparam int CUSC_USB_DIV_DIS_BIT = 6;

    // ==========================================================
    // oscillator_control_zero fields
    localparam int CUSC_SPEED_LSB = 0;
    localparam int CUSC_SPEED_W = 3;
    localparam int CUSC_SLEEP_LSB = 3;
    localparam int CUSC_SLEEP_W = 2;
    localparam int CUSC_NO_BUZZ_BIT = 5;

    // ==========================================================
    // detector duty timing
    localparam int CUSC_CLK_PERIOD_NS = 50;
    localparam int CUSC_DUTY_ON_NS = 2000;
    localparam int CUSC_DUTY_PERIOD_BASE_US = 16;
    localparam int CUSC_DUTY_CNT_W = 12;
    // least time, rounded up
    localparam logic [11:0] CUSC_DUTY_ON_CYC =
        12'((CUSC_DUTY_ON_NS + CUSC_CLK_PERIOD_NS - 1) / CUSC_CLK_PERIOD_NS);
    // base period, rounded down; doubled per step of the duty trim
    localparam logic [11:0] CUSC_DUTY_BASE_CYC =
        12'((CUSC_DUTY_PERIOD_BASE_US * 1000) / CUSC_CLK_PERIOD_NS);
    localparam logic [11:0] CUSC_CNT_ZERO = 12'h000;
    localparam logic [11:0] CUSC_CNT_ONE = 12'h001;

    typedef enum logic [2:0] {
        CUSC_DT_IDLE = 3'b001,
        CUSC_DT_ON = 3'b010,
        CUSC_DT_OFF = 3'b100
    } cusc_duty_state_t;

endpackage

//--- logic/cusc_duty_timer.sv
// Purpose: periodic enable of the low voltage and power-on detector during sleep
// Assumes: run and duty_trim are synchronous to clk
// Notes: timing depends only on duty_trim, never on the sleep interval field
`timescale 1ns/1ps
`default_nettype none
module cusc_duty_timer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [1:0] duty_trim,
    output logic duty_on
);
    import cusc_pkg::*;

    // ==========================================================
    // period select
    cusc_duty_state_t state_reg;
    cusc_duty_state_t state_next;
    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;
    logic duty_on_reg;
    wire [11:0] period_cyc = CUSC_DUTY_BASE_CYC << duty_trim;
    wire [11:0] off_cyc = period_cyc - CUSC_DUTY_ON_CYC;
    wire on_done = cnt_reg == CUSC_DUTY_ON_CYC - CUSC_CNT_ONE;
    wire off_done = cnt_reg >= off_cyc - CUSC_CNT_ONE;

    // ==========================================================
    // sequencer
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + CUSC_CNT_ONE;
        case (state_reg)
            CUSC_DT_IDLE: begin
                cnt_next = CUSC_CNT_ZERO;
                if (run) begin
                    state_next = CUSC_DT_ON;
                end
            end
            CUSC_DT_ON: begin
                if (on_done) begin
                    state_next = CUSC_DT_OFF;
                    cnt_next = CUSC_CNT_ZERO;
                end
            end
            CUSC_DT_OFF: begin
                if (off_done) begin
                    state_next = CUSC_DT_ON;
                    cnt_next = CUSC_CNT_ZERO;
                end
            end
            default: begin
                state_next = CUSC_DT_IDLE;
                cnt_next = CUSC_CNT_ZERO;
            end
        endcase
        if (!run) begin
            state_next = CUSC_DT_IDLE;
            cnt_next = CUSC_CNT_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= CUSC_DT_IDLE;
            cnt_reg <= CUSC_CNT_ZERO;
            duty_on_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            duty_on_reg <= state_next == CUSC_DT_ON;
        end
    end

    assign duty_on = duty_on_reg;

    // ==========================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    on_phase_end_a: assert property (
        (state_reg == CUSC_DT_ON) && on_done && run |=> (state_reg == CUSC_DT_OFF) && !duty_on_reg)
        else $error("detector on phase did not end after its count");

    sequence s_trim_steady;
        run && $stable(duty_trim);
    endsequence

    off_phase_end_a: assert property (
        (((state_reg == CUSC_DT_OFF) && off_done) and s_trim_steady) |=> duty_on_reg && (cnt_reg == CUSC_CNT_ZERO))
        else $error("detector off phase did not end after its period");

endmodule
`default_nettype wire

//--- sim/tb_cusc_top.sv
// Purpose: self-checking bench for the clock select and detector duty block
// Assumes: ref_clk at 20 MHz, apb master on rising edges, bounded waits
// Notes: integer register model, compared at every read and output check
`timescale 1ns/1ps
`default_nettype none
module tb_cusc_top;
    import cusc_pkg::*;
    // ==========================================================
    // signals
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sleep_pin = 1'b0;
    logic [1:0] duty_trim_pin = 2'b00;
    logic processor_clock_sel;
    logic bus_engine_clock_sel;
    logic bus_engine_halve;
    logic [1:0] sleep_timer_sel;
    logic [2:0] processor_speed;
    logic low_voltage_detect_en;
    int n_errors = 0;
    int cmp_count = 0;
    logic [31:0] rnd = 32'h9191;
    logic [31:0] rd;
    logic err;
    logic [7:0] cfg_m;
    logic [7:0] osc_m;
    int n_on;
    int n_off;
    int n_skip;

    always #25 ref_clk = ~ref_clk;

    cusc_top dut (
        .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_pin(sleep_pin), .duty_trim_pin(duty_trim_pin),
        .processor_clock_sel(processor_clock_sel), .bus_engine_clock_sel(bus_engine_clock_sel),
        .bus_engine_halve(bus_engine_halve), .sleep_timer_sel(sleep_timer_sel),
        .processor_speed(processor_speed), .low_voltage_detect_en(low_voltage_detect_en)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (k == 20) begin
            $display("FAIL apb wait expected %h seen %h", 1, 0);
            n_errors++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic count_level(input logic lvl, output int n);
        // the edge that ended the previous level is the first of this one
        n = 1;
        while (n < 6000) begin
            @(posedge ref_clk);
            if (low_voltage_detect_en !== lvl) begin
                break;
            end
            n++;
        end
        if (n == 6000) begin
            $display("FAIL duty wait expected %h seen %h", !lvl, lvl);
            n_errors++;
            stop_test();
        end
    endtask

    task automatic chk_outs();
        repeat (3) @(posedge ref_clk);
        chk("processor_clock_sel", cfg_m[0], processor_clock_sel);
        chk("bus_engine_clock_sel", cfg_m[5], bus_engine_clock_sel);
        chk("bus_engine_halve", !(cfg_m[5] && cfg_m[6]), bus_engine_halve);
        chk("sleep_timer_sel", osc_m[4:3], sleep_timer_sel);
        chk("processor_speed", osc_m[2:0], processor_speed);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        cfg_m = 8'h00;
        osc_m = 8'h00;
        chk_outs();
        apb(1'b0, CUSC_CLK_CFG_OFS, 32'h0);
        chk("cfg reset", 32'h0, rd);
        apb(1'b0, CUSC_OSC_CTL0_OFS, 32'h0);
        chk("osc reset", 32'h0, rd);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            cfg_m = {rnd[7], i[1:0], rnd[4:0]} & 8'h61;
            apb(1'b1, CUSC_CLK_CFG_OFS, {rnd[31:8], rnd[7], i[1:0], rnd[4:0]});
            apb(1'b0, CUSC_CLK_CFG_OFS, 32'h0);
            chk("cfg read", {24'h0, cfg_m}, rd);
            osc_m = rnd[15:8] & 8'h3f;
            apb(1'b1, CUSC_OSC_CTL0_OFS, {24'h0, rnd[15:8]});
            apb(1'b0, CUSC_OSC_CTL0_OFS, 32'h0);
            chk("osc read", {24'h0, osc_m}, rd);
            chk_outs();
        end
        $display("test register access done");
        apb(1'b1, 12'h034, 32'hffff_ffff);
        chk("unmapped write err", 1, err);
        apb(1'b0, 12'h034, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped read err", 1, err);
        apb(1'b0, CUSC_CLK_CFG_OFS, 32'h0);
        chk("cfg kept", {24'h0, cfg_m}, rd);
        $display("test unmapped done");
        osc_m = 8'h20;
        apb(1'b1, CUSC_OSC_CTL0_OFS, 32'h0000_0020);
        sleep_pin <= 1'b1;
        n_off = 0;
        repeat (3000) begin
            @(posedge ref_clk);
            if (low_voltage_detect_en !== 1'b1) begin
                n_off++;
            end
        end
        chk("no-buzz low cycles", 0, n_off);
        $display("test no-buzz done");
        for (int t = 0; t < 4; t++) begin
            sleep_pin <= 1'b0;
            duty_trim_pin <= t[1:0];
            rnd = xs(rnd);
            osc_m = rnd[7:0] & 8'h1f;
            apb(1'b1, CUSC_OSC_CTL0_OFS, {24'h0, osc_m});
            repeat (5) @(posedge ref_clk);
            chk("awake enable", 1, low_voltage_detect_en);
            sleep_pin <= 1'b1;
            count_level(1'b1, n_skip);
            osc_m = osc_m ^ 8'h18;
            apb(1'b1, CUSC_OSC_CTL0_OFS, {24'h0, osc_m});
            count_level(1'b0, n_skip);
            count_level(1'b1, n_on);
            count_level(1'b0, n_off);
            chk("sleep field in sleep", osc_m[4:3], sleep_timer_sel);
            chk("duty on", int'(CUSC_DUTY_ON_CYC), n_on);
            chk("duty off", (int'(CUSC_DUTY_BASE_CYC) << t) - int'(CUSC_DUTY_ON_CYC), n_off);
        end
        $display("test duty done");
        stop_test();
    end
endmodule
`default_nettype wire
